// ---- rtl/brf_top.sv ----
// banked general register file with dsp and fpu registers, ahb-lite cfg
// Function
// - user mode normally, exceptions enter privileged
// - general, control and fp registers are 32 bits
// - sixteen visible registers, 0..7 banked twice
// - privileged bank chosen by bank_select_bit
// - bit one: alternate visible, primary via hidden port
// - bit zero: primary visible, alternate via hidden port
// - user mode: primary only, alternate unreachable
// - x pointers from R4/R5, index R8
// - y address pointer from R6/R7
// - y index pointer from R9
// - single pointers R2..R5, index R8
// - two 40-bit, six 32-bit dsp data registers
// - 32-bit wrap bound control register
// - 32-bit loop first and last registers
// - loop count held inside status word
// - sixteen 32-bit floating-point registers
// - x and y pointer sets supplied concurrently
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module brf_top
   import brf_pkg::*;
(
   input  wire logic        hclk,          // core clock
   input  wire logic        hresetn,       // async reset, low
   input  wire logic        ce,            // clock enable
   // ahb-lite slave
   input  wire logic        hsel,          // slave select
   input  wire logic [7:0]  haddr,         // byte address
   input  wire logic [1:0]  htrans,        // transfer type
   input  wire logic        hwrite,        // write not read
   input  wire logic [2:0]  hsize,         // word only
   input  wire logic [31:0] hwdata,        // write data
   input  wire logic        hready,        // bus ready in
   output logic             hreadyout,     // slave ready
   output logic             hresp,         // always okay
   output logic [31:0]      hrdata,        // read data
   // mode events from the pipeline
   input  wire logic        exc_take,      // exception taken pulse
   input  wire logic        exc_return,    // return to user pulse
   input  wire logic        loop_step,     // loop iteration done
   // general register ports
   input  wire logic [3:0]  rd_a_idx,      // read port a index
   input  wire logic [3:0]  rd_b_idx,      // read port b index
   output logic [31:0]      rd_a_data,     // read port a data
   output logic [31:0]      rd_b_data,     // read port b data
   input  wire logic        wr_en,         // general write strobe
   input  wire logic [3:0]  wr_idx,        // general write index
   input  wire logic [31:0] wr_data,       // general write data
   // load/store control path to the hidden bank
   input  wire logic        hbw_en,        // load_control_instr
   input  wire logic [2:0]  hbw_idx,       // hidden bank index
   input  wire logic [31:0] hbw_data,      // value to load
   input  wire logic [2:0]  hbr_idx,       // store_control_instr idx
   output logic [31:0]      hbr_data,      // hidden bank value
   // dsp pointer outputs
   input  wire logic        x_sel,         // 0: R4, 1: R5
   input  wire logic        y_sel,         // 0: R6, 1: R7
   input  wire logic [1:0]  s_sel,         // R2..R5
   output logic [31:0]      x_addr_ptr,    // x address pointer
   output logic [31:0]      x_index_ptr,   // x index pointer
   output logic [31:0]      y_addr_ptr,    // y address pointer
   output logic [31:0]      y_index_ptr,   // y index pointer
   output logic [31:0]      s_addr_ptr,    // single address pointer
   output logic [31:0]      single_index_ptr, // single index
   // floating-point register port
   input  wire logic [3:0]  fp_rd_idx,     // fp read index
   output logic [31:0]      fp_rd_data,    // fp read data
   input  wire logic        fp_wr_en,      // fp write strobe
   input  wire logic [3:0]  fp_wr_idx,     // fp write index
   input  wire logic [31:0] fp_wr_data,    // fp write data
   output logic             priv_mode,     // privileged mode
   output logic             bank_sel       // bank_select_bit
);
   // ==========================================================
   // state
   logic [31:0]           gpr_r [BRF_NPHYS];     // general regs
   logic                  priv_r;                // processing mode
   logic                  bank_r;                // bank_select_bit
   logic                  dspe_r;                // dsp enable
   logic [BRF_LCNT_W-1:0] lcnt_r;                // loop_count_field
   logic [31:0]           wrap_r;                // wrap_bound_reg
   logic [31:0]           lfirst_r;              // loop_first_addr
   logic [31:0]           llast_r;               // loop_last_addr
   logic [BRF_ACC_W-1:0]  acc_r [2];             // wide dsp data
   logic [31:0]           dspn_r [BRF_NDSP_N];   // narrow dsp data
   logic                  pend_r;                // data phase owed
   logic                  pwr_r;                 // pending is write
   logic [7:0]            paddr_r;               // pending address

   // ==========================================================
   // mapping functions
   // physical slot of a visible index under the current mode
   function automatic logic [4:0] phys_of(input logic [3:0] idx,
                                          input logic priv,
                                          input logic bank);
      logic alt;
      alt = priv & bank;
      if (idx[3]) begin
         phys_of = {1'b0, idx};
      end else if (alt) begin
         phys_of = BRF_ALT_BASE | {2'b00, idx[2:0]};
      end else begin
         phys_of = BRF_PRI_BASE | {2'b00, idx[2:0]};
      end
   endfunction : phys_of

   // physical slot of the bank that ordinary instructions cannot see
   function automatic logic [4:0] hidden_of(input logic [2:0] idx,
                                            input logic bank);
      hidden_of = (bank ? BRF_PRI_BASE : BRF_ALT_BASE)
                | {2'b00, idx};
   endfunction : hidden_of

   // ==========================================================
   // decode
   wire        ahb_take  = hsel & hready & htrans[1] & hreadyout;
   wire        ahb_wr    = pend_r & pwr_r;                // write now
   wire [4:0]  wr_phys   = phys_of(wr_idx, priv_r, bank_r);
   wire [4:0]  hbw_phys  = hidden_of(hbw_idx, bank_r);
   wire [4:0]  hbr_phys  = hidden_of(hbr_idx, bank_r);
   wire        hbw_ok    = hbw_en & priv_r;
   wire        sw_wr     = ahb_wr & (paddr_r == BRF_A_STATUS);
   wire        lcnt_dec  = loop_step & (lcnt_r != '0);
   wire [3:0]  x_reg     = BRF_R_XADR0 | {3'b000, x_sel};
   wire [3:0]  y_reg     = BRF_R_YADR0 | {3'b000, y_sel};
   wire [3:0]  s_reg     = BRF_R_SIDX0 + {2'b00, s_sel};
   wire [31:0] x_val     = gpr_r[phys_of(x_reg, priv_r, bank_r)];
   wire [31:0] y_val     = gpr_r[phys_of(y_reg, priv_r, bank_r)];
   wire [31:0] s_val     = gpr_r[phys_of(s_reg, priv_r, bank_r)];
   wire [31:0] status_w  = {1'b0, priv_r, bank_r, dspe_r,
                            lcnt_r, 16'h0000};
   wire [7:0]  dspn_off  = paddr_r - BRF_A_DSPN;
   wire        dspn_hit  = (paddr_r >= BRF_A_DSPN)
                         & (dspn_off[7:2] < 6'(BRF_NDSP_N))
                         & (paddr_r[1:0] == 2'b00);

   // read mux of the register map, unmapped words read zero
   logic [31:0] map_rd;
   always_comb begin
      map_rd = 32'h0000_0000;
      case (paddr_r)
         BRF_A_STATUS:       map_rd = status_w;
         BRF_A_WRAP:         map_rd = wrap_r;
         BRF_A_LFIRST:       map_rd = lfirst_r;
         BRF_A_LLAST:        map_rd = llast_r;
         BRF_A_ACC0:         map_rd = acc_r[0][31:0];
         BRF_A_ACC0 + 8'h04: map_rd = {24'h0, acc_r[0][39:32]};
         BRF_A_ACC1:         map_rd = acc_r[1][31:0];
         BRF_A_ACC1 + 8'h04: map_rd = {24'h0, acc_r[1][39:32]};
         default: begin
            if (dspn_hit) begin
               map_rd = dspn_r[dspn_off[4:2]];
            end
         end
      endcase
   end

   // ==========================================================
   // ahb-lite slave: one wait state, write and read in data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r    <= 1'b0;
         pwr_r     <= 1'b0;
         paddr_r   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else if (ce) begin
         if (ahb_take) begin
            // capture address phase, stall the data phase once
            pend_r    <= 1'b1;
            pwr_r     <= hwrite;
            paddr_r   <= {haddr[7:2], 2'b00};
            hreadyout <= 1'b0;
         end else if (pend_r) begin
            pend_r    <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= pwr_r ? 32'h0000_0000 : map_rd;
         end
      end
   end

   // ==========================================================
   // status word: mode, bank select, dsp enable, loop count
   // exception entry overrides a software write of priv and bank, return one of priv; a software write overrides a loop step
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         priv_r <= BRF_RST_PRIV;
         bank_r <= BRF_RST_BANK;
         dspe_r <= BRF_RST_DSPE;
         lcnt_r <= '0;
      end else if (ce) begin
         if (sw_wr) begin
            priv_r <= hwdata[BRF_SW_PRIV];
            bank_r <= hwdata[BRF_SW_BANK];
            dspe_r <= hwdata[BRF_SW_DSPE];
            lcnt_r <= hwdata[BRF_SW_LCLO +: BRF_LCNT_W];
         end else if (lcnt_dec) begin
            lcnt_r <= lcnt_r - 1'b1;
         end
         if (exc_take) begin
            priv_r <= 1'b1;
            bank_r <= 1'b1;
         end else if (exc_return) begin
            priv_r <= 1'b0;
         end
      end
   end

   // control and dsp data registers written from the bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wrap_r   <= BRF_RST_WORD;
         lfirst_r <= BRF_RST_WORD;
         llast_r  <= BRF_RST_WORD;
         acc_r    <= '{default: '0};
         dspn_r   <= '{default: '0};
      end else if (ce && ahb_wr) begin
         case (paddr_r)
            BRF_A_WRAP:         wrap_r          <= hwdata;
            BRF_A_LFIRST:       lfirst_r        <= hwdata;
            BRF_A_LLAST:        llast_r         <= hwdata;
            BRF_A_ACC0:         acc_r[0][31:0]  <= hwdata;
            BRF_A_ACC0 + 8'h04: acc_r[0][39:32] <= hwdata[7:0];
            BRF_A_ACC1:         acc_r[1][31:0]  <= hwdata;
            BRF_A_ACC1 + 8'h04: acc_r[1][39:32] <= hwdata[7:0];
            default: begin
               if (dspn_hit) begin
                  dspn_r[dspn_off[4:2]] <= hwdata;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // general registers; hbw only reaches the hidden bank, so it can
   // never collide with an ordinary write to a visible slot
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpr_r <= '{default: '0};
      end else if (ce) begin
         if (wr_en) begin
            gpr_r[wr_phys] <= wr_data;
         end
         if (hbw_ok) begin
            gpr_r[hbw_phys] <= hbw_data;
         end
      end
   end

   // registered read ports, old value on a same-cycle write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_a_data <= '0;
         rd_b_data <= '0;
         hbr_data  <= '0;
      end else if (ce) begin
         rd_a_data <= gpr_r[phys_of(rd_a_idx, priv_r, bank_r)];
         rd_b_data <= gpr_r[phys_of(rd_b_idx, priv_r, bank_r)];
         hbr_data  <= priv_r ? gpr_r[hbr_phys] : '0;
      end
   end

   // ==========================================================
   // dsp pointers: both sets each cycle so x and y run together;
   // they read zero while the extension is off to save toggling
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         x_addr_ptr       <= '0;
         x_index_ptr      <= '0;
         y_addr_ptr       <= '0;
         y_index_ptr      <= '0;
         s_addr_ptr       <= '0;
         single_index_ptr <= '0;
      end else if (ce) begin
         x_addr_ptr       <= dspe_r ? x_val : '0;
         x_index_ptr      <= dspe_r ? gpr_r[BRF_R_XIDX] : '0;
         y_addr_ptr       <= dspe_r ? y_val : '0;
         y_index_ptr      <= dspe_r ? gpr_r[BRF_R_YIDX] : '0;
         s_addr_ptr       <= dspe_r ? s_val : '0;
         single_index_ptr <= dspe_r ? gpr_r[BRF_R_XIDX] : '0;
      end
   end

   // mode outputs mirror the status flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         priv_mode <= BRF_RST_PRIV;
         bank_sel  <= BRF_RST_BANK;
      end else if (ce) begin
         priv_mode <= priv_r;
         bank_sel  <= bank_r;
      end
   end

   // ==========================================================
   // floating-point registers
   brf_mem #(
      .WIDTH (BRF_XLEN),
      .DEPTH (BRF_NFPR),
      .AW    (4)
   ) u_fpr (
      .clk     (hclk),
      .rst_n   (hresetn),
      .ce      (ce),
      .wr_en   (fp_wr_en),
      .wr_addr (fp_wr_idx),
      .wr_data (fp_wr_data),
      .rd_addr (fp_rd_idx),
      .rd_data (fp_rd_data)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_take;
      ce && ahb_take;
   endsequence
   sequence s_wait_done;
      !hreadyout ##1 (hreadyout || !ce);
   endsequence

   exc_enters_priv_a: assert property (ce && exc_take |=> priv_r)
      else $error("exception did not enter privileged mode");
   user_primary_a: assert property (
      ce && !priv_r && rd_a_idx == 4'h3 |=> rd_a_data == $past(gpr_r[3]))
      else $error("user mode read not from primary bank");
   alt_bank_a: assert property (
      ce && priv_r && bank_r && rd_b_idx == 4'h2
      |=> rd_b_data == $past(gpr_r[18]))
      else $error("bank one read not from alternate bank");
   pri_bank_a: assert property (
      ce && priv_r && !bank_r && hbr_idx == 3'h1
      |=> hbr_data == $past(gpr_r[17]))
      else $error("hidden access not to alternate bank");
   hbr_user_zero_a: assert property (
      ce && !priv_r |=> hbr_data == 32'h0000_0000)
      else $error("hidden bank visible in user mode");
   x_index_a: assert property (
      ce && dspe_r |=> x_index_ptr == $past(gpr_r[8]))
      else $error("x index pointer not from register 8");
   y_index_a: assert property (
      ce && dspe_r |=> y_index_ptr == $past(gpr_r[9]))
      else $error("y index pointer not from register 9");
   y_addr_a: assert property (
      ce && dspe_r && y_sel && priv_r && bank_r
      |=> y_addr_ptr == $past(gpr_r[23]))
      else $error("y address pointer not from register 7");
   loop_dec_a: assert property (
      ce && lcnt_dec && !sw_wr |=> lcnt_r == $past(lcnt_r) - 1'b1)
      else $error("loop count did not step down by one");
   bus_wait_a: assert property (s_take |=> s_wait_done)
      else $error("bus data phase not one wait state");
endmodule : brf_top

// ---- rtl/brf_pkg.sv ----
// constants shared by the banked register file and its storage macro
package brf_pkg;
   // ==========================================================
   // widths and counts
   localparam int unsigned BRF_XLEN     = 32;  // general and fp registers
   localparam int unsigned BRF_NGPR     = 16;  // visible general regs
   localparam int unsigned BRF_NBANKED  = 8;   // indices 0..7 banked
   localparam int unsigned BRF_NPHYS    = 24;  // 8 + 8 + 8 physical
   localparam int unsigned BRF_NFPR     = 16;  // floating-point regs
   localparam int unsigned BRF_ACC_W    = 40;  // wide dsp data regs
   localparam int unsigned BRF_NDSP_N   = 6;   // 32-bit dsp data regs
   localparam int unsigned BRF_LCNT_W   = 12;  // loop count width
   // ==========================================================
   // physical slots of the general registers
   localparam logic [4:0] BRF_PRI_BASE  = 5'h00; // primary_bank 0..7
   localparam logic [4:0] BRF_ALT_BASE  = 5'h10; // alternate_bank
   // ==========================================================
   // fixed pointer registers of the dsp extension
   localparam logic [3:0] BRF_R_SIDX0   = 4'h2; // single address base
   localparam logic [3:0] BRF_R_XADR0   = 4'h4; // x address R4/R5
   localparam logic [3:0] BRF_R_YADR0   = 4'h6; // y address R6/R7
   localparam logic [3:0] BRF_R_XIDX    = 4'h8; // x and single index
   localparam logic [3:0] BRF_R_YIDX    = 4'h9; // y index
   // ==========================================================
   // status_word field positions
   localparam int unsigned BRF_SW_PRIV  = 30;  // privileged mode
   localparam int unsigned BRF_SW_BANK  = 29;  // bank_select_bit
   localparam int unsigned BRF_SW_DSPE  = 28;  // dsp extension enable
   localparam int unsigned BRF_SW_LCLO  = 16;  // loop_count_field lsb
   // ==========================================================
   // byte offsets on the ahb-lite slave
   localparam logic [7:0] BRF_A_STATUS  = 8'h00; // status_word
   localparam logic [7:0] BRF_A_WRAP    = 8'h04; // wrap_bound_reg
   localparam logic [7:0] BRF_A_LFIRST  = 8'h08; // loop_first_addr
   localparam logic [7:0] BRF_A_LLAST   = 8'h0c; // loop_last_addr
   localparam logic [7:0] BRF_A_ACC0    = 8'h20; // acc0 lo, hi at +4
   localparam logic [7:0] BRF_A_ACC1    = 8'h28; // acc1 lo, hi at +4
   localparam logic [7:0] BRF_A_DSPN    = 8'h30; // six words 30..44
   // ==========================================================
   // reset values: reset acts as an exception, so privileged, bank 1
   localparam logic BRF_RST_PRIV        = 1'b1;
   localparam logic BRF_RST_BANK        = 1'b1;
   localparam logic BRF_RST_DSPE        = 1'b0;
   localparam logic [31:0] BRF_RST_WORD = 32'h0000_0000;
endpackage : brf_pkg

// ---- rtl/brf_mem.sv ----
// small register-array memory with one write and one registered read
`timescale 1ns/1ps
module brf_mem
   import brf_pkg::*;
#(
   parameter int unsigned WIDTH = BRF_XLEN,  // word width
   parameter int unsigned DEPTH = BRF_NFPR,  // number of words
   parameter int unsigned AW    = 4          // address width
)(
   input  wire logic             clk,      // core clock
   input  wire logic             rst_n,    // async reset, low
   input  wire logic             ce,       // freezes state when low
   input  wire logic             wr_en,    // write strobe
   input  wire logic [AW-1:0]    wr_addr,  // write address
   input  wire logic [WIDTH-1:0] wr_data,  // write data
   input  wire logic [AW-1:0]    rd_addr,  // read address
   output logic      [WIDTH-1:0] rd_data   // registered read data
);
   // ==========================================================
   // storage
   logic [WIDTH-1:0] mem_r [DEPTH];  // word array

   // array write; no reset so it maps onto plain storage
   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // read register, old data on a same-cycle write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule : brf_mem

// ---- verif/brf_pipe_model.sv ----
// pipeline model: turns event codes into mode pulses one cycle later
`timescale 1ns/1ps
module brf_pipe_model (
   input  wire logic       hclk,       // core clock
   input  wire logic       hresetn,    // async reset, low
   input  wire logic [1:0] ev,         // 1 trap, 2 return, 3 loop pass
   output logic            exc_take,   // exception taken
   output logic            exc_return, // back to user mode
   output logic            loop_step   // one loop pass done
);
   // ==========================================================
   // event pulses
   // registered so each pulse is clean and lasts as long as its event code is held
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exc_take   <= 1'b0;
         exc_return <= 1'b0;
         loop_step  <= 1'b0;
      end else begin
         exc_take   <= (ev == 2'h1);
         exc_return <= (ev == 2'h2);
         loop_step  <= (ev == 2'h3);
      end
   end
endmodule : brf_pipe_model

// ---- verif/banked_register_file_tb.sv ----
// self-checking bench for the banked register file
`timescale 1ns/1ps
module banked_register_file_tb
   import brf_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        wr_en = 1'b0, hbw_en = 1'b0, x_sel = 1'b0, y_sel = 1'b0;
   logic        fp_wr_en = 1'b0, ce = 1'b1;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0, ev = 2'h0, s_sel = 2'h0;
   logic [3:0]  rd_a_idx = 4'h0, rd_b_idx = 4'h0, wr_idx = 4'h0;
   logic [3:0]  fp_rd_idx = 4'h0, fp_wr_idx = 4'h0;
   logic [2:0]  hbw_idx = 3'h0, hbr_idx = 3'h0;
   logic [31:0] hwdata = 32'h0, wr_data = 32'h0, hbw_data = 32'h0;
   logic [31:0] fp_wr_data = 32'h0, seed = 32'h6e8d, r;
   logic [31:0] v [0:15], pri [0:7], alt [0:7], cw [0:12];
   wire logic   hreadyout, hresp, exc_take, exc_return, loop_step;
   wire logic   priv_mode, bank_sel;
   wire logic [31:0] hrdata, rd_a_data, rd_b_data, hbr_data, fp_rd_data;
   wire logic [31:0] x_addr_ptr, x_index_ptr, y_addr_ptr, y_index_ptr;
   wire logic [31:0] s_addr_ptr, single_index_ptr;
   int          fails = 0, n_compared = 0;
   always #2 hclk = ~hclk; // 250 MHz
   // ==========================================================
   // design and pipeline model; ready loops back as on a one-slave bus
   brf_top i_brf_top (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
      .hresp, .hrdata, .exc_take, .exc_return, .loop_step, .rd_a_idx,
      .rd_b_idx, .rd_a_data, .rd_b_data, .wr_en, .wr_idx, .wr_data,
      .hbw_en, .hbw_idx, .hbw_data, .hbr_idx, .hbr_data, .x_sel, .y_sel,
      .s_sel, .x_addr_ptr, .x_index_ptr, .y_addr_ptr, .y_index_ptr,
      .s_addr_ptr, .single_index_ptr, .fp_rd_idx, .fp_rd_data, .fp_wr_en,
      .fp_wr_idx, .fp_wr_data, .priv_mode, .bank_sel);
   brf_pipe_model i_brf_pipe_model (.hclk, .hresetn, .ev, .exc_take,
      .exc_return, .loop_step);
   // ==========================================================
   // expectation helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // status word as the block should show it
   function automatic logic [31:0] sw(logic p, logic b, logic d,
                                      logic [11:0] c);
      return {1'b0, p, b, d, c, 16'h0000};
   endfunction : sw
   // control word i: 04..0c, then the dsp words 20..44
   function automatic logic [7:0] ca(int i);
      return (i < 3) ? 8'(4 + 4 * i) : 8'(8'h20 + 4 * (i - 3));
   endfunction : ca
   // accumulator top words keep only bits 39:32
   function automatic logic [31:0] keep(logic [7:0] a, logic [31:0] d);
      return (a == 8'h24 || a == 8'h2c) ? {24'h0, d[7:0]} : d;
   endfunction : keep
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // one ahb-lite single word transfer; a hang is ended by the watchdog
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask : ahb
   task automatic rd(logic [7:0] a, logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk($sformatf("word %h", a), e, r);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rd
   task automatic gw(logic l, logic [3:0] i, logic [31:0] d);
      @(posedge hclk);
      {wr_en, hbw_en} <= {~l, l};
      {wr_idx, hbw_idx, wr_data, hbw_data} <= {i, i[2:0], d, d};
      @(posedge hclk);
      {wr_en, hbw_en} <= 2'b00;
   endtask : gw
   // visible read on both ports plus the hidden-bank store path
   task automatic look(logic [3:0] i, logic [31:0] eg, logic [31:0] es);
      @(posedge hclk);
      {rd_a_idx, rd_b_idx, hbr_idx} <= {i, i, i[2:0]};
      @(posedge hclk);
      @(negedge hclk);
      chk("rd_a_data", eg, rd_a_data);
      chk("rd_b_data", eg, rd_b_data);
      if (i < 8) chk("hbr_data", es, hbr_data);
   endtask : look
   task automatic evt(logic [1:0] c);
      @(posedge hclk);
      ev <= c;
      @(posedge hclk);
      ev <= 2'h0;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask : evt
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // ==========================================================
   // watchdog: the sequence needs a few hundred cycles
   initial begin
      #80000;
      fails++;
      close_out();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk("mode", 32'h3, {30'h0, priv_mode, bank_sel});
      rd(BRF_A_STATUS, sw(1'b1, 1'b1, 1'b0, 12'h0));
      for (int i = 0; i < 8; i++) begin
         alt[i] = rnd();
         pri[i] = rnd();
         gw(1'b0, 4'(i), alt[i]);
         gw(1'b1, 4'(i), pri[i]);
      end
      for (int i = 0; i < 8; i++) look(4'(i), alt[i], pri[i]);
      ahb(1'b1, BRF_A_STATUS, sw(1'b1, 1'b0, 1'b0, 12'h0));
      for (int i = 0; i < 8; i++) look(4'(i), pri[i], alt[i]);
      for (int i = 8; i < 16; i++) begin
         v[i] = rnd();
         gw(1'b0, 4'(i), v[i]);
         look(4'(i), v[i], 32'h0);
      end
      // a write while ce is low must leave every flop alone
      @(posedge hclk);
      ce <= 1'b0;
      gw(1'b0, 4'hf, ~v[15]);
      ce <= 1'b1;
      look(4'hf, v[15], 32'h0);
      evt(2'h2);
      chk("user", 32'h0, {31'h0, priv_mode});
      gw(1'b1, 4'h0, ~alt[0]);
      for (int i = 0; i < 8; i++) look(4'(i), pri[i], 32'h0);
      evt(2'h1);
      chk("trap", 32'h3, {30'h0, priv_mode, bank_sel});
      look(4'h0, alt[0], pri[0]);
      ahb(1'b1, BRF_A_STATUS, sw(1'b1, 1'b1, 1'b1, 12'h003));
      for (int i = 2; i < 10; i++) begin
         v[i] = rnd();
         gw(1'b0, 4'(i), v[i]);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge hclk);
         {x_sel, y_sel, s_sel} <= {i[0], i[1], 2'(i)};
         repeat (2) @(posedge hclk);
         @(negedge hclk);
         chk("x_addr_ptr", v[4 + i[0]], x_addr_ptr);
         chk("x_index_ptr", v[8], x_index_ptr);
         chk("y_addr_ptr", v[6 + i[1]], y_addr_ptr);
         chk("y_index_ptr", v[9], y_index_ptr);
         chk("s_addr_ptr", v[2 + i], s_addr_ptr);
         chk("s_idx", v[8], single_index_ptr);
      end
      // four passes from three: the count must stop at zero
      for (int i = 0; i < 4; i++) evt(2'h3);
      rd(BRF_A_STATUS, sw(1'b1, 1'b1, 1'b1, 12'h0));
      for (int i = 0; i < 13; i++) begin
         cw[i] = rnd();
         ahb(1'b1, ca(i), cw[i]);
      end
      for (int i = 0; i < 13; i++) rd(ca(i), keep(ca(i), cw[i]));
      ahb(1'b1, 8'h80, rnd());
      rd(8'h80, 32'h0);
      for (int i = 0; i < 16; i++) begin
         v[i] = rnd();
         @(posedge hclk);
         {fp_wr_en, fp_wr_idx, fp_wr_data} <= {1'b1, 4'(i), v[i]};
      end
      @(posedge hclk);
      fp_wr_en <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge hclk);
         fp_rd_idx <= 4'(i);
         @(posedge hclk);
         @(negedge hclk);
         chk("fp_rd_data", v[i], fp_rd_data);
      end
      close_out();
   end
endmodule : banked_register_file_tb
